// ### verilog/pms_mode_seq.sv
/*
 Operating-mode sequencer with an AXI4-Lite register slave.
 Assumes the execution core reports start-up completion, breakpoints,
 cycle ends and watchdog errors as synchronous one-cycle pulses.
*/
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
// Behaviour
// - four modes: stop, start-up, run, hold
// - no program execution while stopped
// - stop keeps counters, timers, flags, image
// - output lock asserted in stop
// - yellow steady in stop
// - yellow blinks after power-on, then steady
// - start-up routine called on each start
// - start-up unsupervised; may call other blocks
// - output lock held through start-up
// - green blinks at least 3s from start-up; the green timer can fall short by part of one tick
// - green steady in run after start-up
// - watchdog error needs restart plus cold-start routine; an overall reset also clears the lock here
// - run repeats main routine, events allowed
// - run: timers active, image refreshed per cycle
// - output lock released in run
// - hold halts code, freezes timers, locks outputs
// - hold: red on, green blinks 1Hz
`timescale 1ns/1ns
`default_nettype none

module pms_mode_seq #(
   parameter int TICK_CYCLES = pms_pkg::TICK_CYCLES,
   parameter int HALF_MS     = pms_pkg::BLINK_HALF_MS,
   parameter int GREEN_MS    = pms_pkg::GREEN_MIN_MS,
   parameter int PON_MS      = pms_pkg::PON_BLINK_MS
) (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   // Execution core events
   input  wire logic        i_startup_done,
   input  wire logic        i_breakpoint,
   input  wire logic        i_cycle_end,
   input  wire logic        i_watchdog_err,
   input  wire logic        i_cold_start_present,
   // Execution control
   output logic [3:0]       o_mode,
   output logic             o_output_disable_lock,
   output logic             o_exec_enable,
   output logic             o_startup_call,
   output logic             o_startup_routine_active,
   output logic             o_cyclic_main_routine_active,
   output logic             o_cycle_monitor_enable,
   output logic             o_timers_enable,
   output logic             o_event_enable,
   output logic             o_image_refresh,
   // Indicators
   output logic             o_yellow_led,
   output logic             o_green_led,
   output logic             o_red_led,
   // AXI4-Lite write address and data
   input  wire logic [7:0]  i_s_axi_awaddr,
   input  wire logic        i_s_axi_awvalid,
   output logic             o_s_axi_awready,
   input  wire logic [31:0] i_s_axi_wdata,
   input  wire logic [3:0]  i_s_axi_wstrb,
   input  wire logic        i_s_axi_wvalid,
   output logic             o_s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       o_s_axi_bresp,
   output logic             o_s_axi_bvalid,
   input  wire logic        i_s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  i_s_axi_araddr,
   input  wire logic        i_s_axi_arvalid,
   output logic             o_s_axi_arready,
   output logic [31:0]      o_s_axi_rdata,
   output logic [1:0]       o_s_axi_rresp,
   output logic             o_s_axi_rvalid,
   input  wire logic        i_s_axi_rready
);
   initial begin
      if (HALF_MS < 1 || GREEN_MS < 1 || PON_MS < 1) begin
         $error("pms_mode_seq: timing parameters must be positive");
      end
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a[7:2] == o[7:2]);
   endfunction

   // Timing helpers
   pms_tick_if tk ();
   logic grn_busy;
   logic pon_busy;
   logic grn_load;
   logic pon_started_ff;

   pms_tick_div #(
      .TICK_CYCLES (TICK_CYCLES),
      .HALF_MS     (HALF_MS)
   ) u_div (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .tk        (tk)
   );

   pms_ms_timer #(
      .MS_W    (12),
      .LOAD_MS (GREEN_MS)
   ) u_green (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .tk        (tk),
      .i_load    (grn_load),
      .o_busy    (grn_busy)
   );

   pms_ms_timer #(
      .MS_W    (12),
      .LOAD_MS (PON_MS)
   ) u_pon (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .tk        (tk),
      .i_load    (~pon_started_ff),
      .o_busy    (pon_busy)
   );

   // Register file and bus state
   logic        run_req_ff;
   logic        restart_ff;
   logic        oreset_ff;
   logic        resume_ff;
   logic        aw_got_ff;
   logic        w_got_ff;
   logic [7:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        aw_rdy_ff;
   logic        w_rdy_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        ar_rdy_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;

   // Sequencer state
   pms_pkg::pms_mode_t state_ff;
   pms_pkg::pms_mode_t nxt_state;
   logic               wdg_lock_ff;
   logic               lock_ff;
   logic               exec_ff;
   logic               call_ff;
   logic               refresh_ff;
   logic               yel_ff;
   logic               grn_ff;
   logic               red_ff;

   // Write channel
   wire aw_hs    = i_s_axi_awvalid & aw_rdy_ff;
   wire w_hs     = i_s_axi_wvalid & w_rdy_ff;
   wire do_write = aw_got_ff & w_got_ff;
   wire wr_ctrl  = do_write & hit(awaddr_ff, pms_pkg::ADDR_CTRL);
   wire wr_cmd   = do_write & hit(awaddr_ff, pms_pkg::ADDR_CMD);
   wire wr_stat  = do_write & hit(awaddr_ff, pms_pkg::ADDR_STAT);
   wire wr_ok    = wr_ctrl | wr_cmd | wr_stat;
   wire nxt_aw_got = (aw_got_ff & ~do_write) | aw_hs;
   wire nxt_w_got  = (w_got_ff & ~do_write) | w_hs;
   wire nxt_bvalid = do_write | (bvalid_ff & ~i_s_axi_bready);
   wire cmd_lane   = wr_cmd & wstrb_ff[0];
   wire nxt_restart = cmd_lane & wdata_ff[pms_pkg::CMD_RESTART_BIT];
   wire nxt_oreset  = cmd_lane & wdata_ff[pms_pkg::CMD_ORESET_BIT];
   wire nxt_resume  = cmd_lane & wdata_ff[pms_pkg::CMD_RESUME_BIT];
   wire nxt_run_req = (wr_ctrl & wstrb_ff[0]) ?
                      wdata_ff[pms_pkg::CTRL_RUN_BIT] : run_req_ff;

   // Read channel
   wire ar_hs      = i_s_axi_arvalid & ar_rdy_ff;
   wire nxt_rvalid = ar_hs | (rvalid_ff & ~i_s_axi_rready);
   wire rd_ctrl    = hit(i_s_axi_araddr, pms_pkg::ADDR_CTRL);
   wire rd_cmd     = hit(i_s_axi_araddr, pms_pkg::ADDR_CMD);
   wire rd_stat    = hit(i_s_axi_araddr, pms_pkg::ADDR_STAT);
   wire rd_ok      = rd_ctrl | rd_cmd | rd_stat;
   logic [31:0] stat_word;
   logic [31:0] ctrl_word;

   always_comb begin
      ctrl_word = pms_pkg::DATA_ZERO;
      ctrl_word[pms_pkg::CTRL_RUN_BIT] = run_req_ff;
      stat_word = pms_pkg::DATA_ZERO;
      stat_word[pms_pkg::ST_MODE_LSB +: 4] = state_ff;
      stat_word[pms_pkg::ST_WDG_BIT]       = wdg_lock_ff;
      stat_word[pms_pkg::ST_GBUSY_BIT]     = grn_busy;
      stat_word[pms_pkg::ST_YEL_BIT]       = yel_ff;
      stat_word[pms_pkg::ST_GRN_BIT]       = grn_ff;
      stat_word[pms_pkg::ST_RED_BIT]       = red_ff;
      stat_word[pms_pkg::ST_LOCK_BIT]      = lock_ff;
   end

   wire [31:0] rd_word = rd_ctrl ? ctrl_word :
                         rd_stat ? stat_word : pms_pkg::DATA_ZERO;

   // Mode decode
   wire st_stop  = (state_ff == pms_pkg::MODE_STOP);
   wire st_start = (state_ff == pms_pkg::MODE_STARTUP);
   wire st_run   = (state_ff == pms_pkg::MODE_RUN);
   wire st_hold  = (state_ff == pms_pkg::MODE_HOLD);
   wire wdg_hit  = i_watchdog_err & ~st_stop;
   wire cold_ok  = restart_ff & i_cold_start_present;
   wire go_start = st_stop & run_req_ff & (~wdg_lock_ff | cold_ok);
   // Set wins over clear; overall reset, or a restart in stop with cold start present, clears
   wire wdg_clr  = oreset_ff | (st_stop & cold_ok);
   wire nxt_wdg  = wdg_hit | (wdg_lock_ff & ~wdg_clr);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         pms_pkg::MODE_STOP: begin
            if (go_start) begin
               nxt_state = pms_pkg::MODE_STARTUP;
            end
         end
         pms_pkg::MODE_STARTUP: begin
            if (wdg_hit || !run_req_ff) begin
               nxt_state = pms_pkg::MODE_STOP;
            end else if (i_startup_done) begin
               nxt_state = pms_pkg::MODE_RUN;
            end
         end
         pms_pkg::MODE_RUN: begin
            if (wdg_hit || !run_req_ff) begin
               nxt_state = pms_pkg::MODE_STOP;
            end else if (i_breakpoint) begin
               nxt_state = pms_pkg::MODE_HOLD;
            end
         end
         pms_pkg::MODE_HOLD: begin
            if (wdg_hit || !run_req_ff) begin
               nxt_state = pms_pkg::MODE_STOP;
            end else if (resume_ff) begin
               nxt_state = pms_pkg::MODE_RUN;
            end
         end
         default: begin
            nxt_state = pms_pkg::MODE_STOP;
         end
      endcase
   end

   // Outputs derived from the next mode so they align with o_mode
   wire n_stop  = (nxt_state == pms_pkg::MODE_STOP);
   wire n_start = (nxt_state == pms_pkg::MODE_STARTUP);
   wire n_run   = (nxt_state == pms_pkg::MODE_RUN);
   wire n_hold  = (nxt_state == pms_pkg::MODE_HOLD);
   // Lock is released only in run
   wire nxt_lock = ~n_run;
   // No code runs in stop or hold; nothing is cleared on stop
   wire nxt_exec = n_start | n_run;
   wire nxt_call = go_start;
   wire nxt_refresh = (st_start & n_run) |
                      (st_run & n_run & i_cycle_end);
   assign grn_load = go_start;

   // The green timer keeps running after an early stop
   // Window counts from reset, before the timer has loaded
   wire pon_win = pon_busy | ~pon_started_ff;
   wire nxt_yel = n_stop & (pon_win ? tk.phase : 1'b1);
   wire nxt_grn = (n_start | n_hold | grn_busy) ? tk.phase :
                  n_run;
   wire nxt_red = n_hold;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff       <= pms_pkg::MODE_STOP;
         wdg_lock_ff    <= 1'b0;
         lock_ff        <= 1'b1;
         exec_ff        <= 1'b0;
         call_ff        <= 1'b0;
         refresh_ff     <= 1'b0;
         yel_ff         <= 1'b0;
         grn_ff         <= 1'b0;
         red_ff         <= 1'b0;
         pon_started_ff <= 1'b0;
      end else begin
         state_ff       <= nxt_state;
         wdg_lock_ff    <= nxt_wdg;
         lock_ff        <= nxt_lock;
         exec_ff        <= nxt_exec;
         call_ff        <= nxt_call;
         refresh_ff     <= nxt_refresh;
         yel_ff         <= nxt_yel;
         grn_ff         <= nxt_grn;
         red_ff         <= nxt_red;
         pon_started_ff <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_req_ff <= pms_pkg::CTRL_RUN_RESET;
         restart_ff <= 1'b0;
         oreset_ff  <= 1'b0;
         resume_ff  <= 1'b0;
         aw_got_ff  <= 1'b0;
         w_got_ff   <= 1'b0;
         aw_rdy_ff  <= 1'b0;
         w_rdy_ff   <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= pms_pkg::RESP_OKAY;
      end else begin
         run_req_ff <= nxt_run_req;
         restart_ff <= nxt_restart;
         oreset_ff  <= nxt_oreset;
         resume_ff  <= nxt_resume;
         aw_got_ff  <= nxt_aw_got;
         w_got_ff   <= nxt_w_got;
         aw_rdy_ff  <= ~nxt_aw_got & ~nxt_bvalid;
         w_rdy_ff   <= ~nxt_w_got & ~nxt_bvalid;
         bvalid_ff  <= nxt_bvalid;
         if (do_write) begin
            bresp_ff <= wr_ok ? pms_pkg::RESP_OKAY : pms_pkg::RESP_SLVERR;
         end
      end
   end

   // Payload holders need no reset
   always_ff @(posedge i_ref_clk) begin
      if (aw_hs) begin
         awaddr_ff <= i_s_axi_awaddr;
      end
      if (w_hs) begin
         wdata_ff <= i_s_axi_wdata;
         wstrb_ff <= i_s_axi_wstrb;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ar_rdy_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff  <= pms_pkg::DATA_ZERO;
         rresp_ff  <= pms_pkg::RESP_OKAY;
      end else begin
         ar_rdy_ff <= ~nxt_rvalid;
         rvalid_ff <= nxt_rvalid;
         if (ar_hs) begin
            rdata_ff <= rd_word;
            rresp_ff <= rd_ok ? pms_pkg::RESP_OKAY : pms_pkg::RESP_SLVERR;
         end
      end
   end

   // Mode-qualified enables are registered from the next mode, like the other outputs
   logic startup_act_ff;
   logic main_act_ff;
   logic mon_en_ff;
   logic tmr_en_ff;
   logic evt_en_ff;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         startup_act_ff <= 1'b0;
         main_act_ff    <= 1'b0;
         mon_en_ff      <= 1'b0;
         tmr_en_ff      <= 1'b0;
         evt_en_ff      <= 1'b0;
      end else begin
         startup_act_ff <= n_start;
         main_act_ff    <= n_run;
         mon_en_ff      <= n_run;
         tmr_en_ff      <= n_run;
         evt_en_ff      <= n_run;
      end
   end

   assign o_mode                       = state_ff;
   assign o_output_disable_lock        = lock_ff;
   assign o_exec_enable                = exec_ff;
   assign o_startup_call               = call_ff;
   assign o_startup_routine_active     = startup_act_ff;
   assign o_cyclic_main_routine_active = main_act_ff;
   assign o_cycle_monitor_enable       = mon_en_ff;
   assign o_timers_enable              = tmr_en_ff;
   assign o_event_enable               = evt_en_ff;
   assign o_image_refresh              = refresh_ff;
   assign o_yellow_led                 = yel_ff;
   assign o_green_led                  = grn_ff;
   assign o_red_led                    = red_ff;
   assign o_s_axi_awready              = aw_rdy_ff;
   assign o_s_axi_wready               = w_rdy_ff;
   assign o_s_axi_bresp                = bresp_ff;
   assign o_s_axi_bvalid               = bvalid_ff;
   assign o_s_axi_arready              = ar_rdy_ff;
   assign o_s_axi_rdata                = rdata_ff;
   assign o_s_axi_rresp                = rresp_ff;
   assign o_s_axi_rvalid               = rvalid_ff;

endmodule // pms_mode_seq

`default_nettype wire

// ### verilog/pms_pkg.sv
/*
 Shared constants and types of the operating-mode sequencer: timing,
 register map, register field positions and the mode encoding.
 Assumes a single system clock at CLK_HZ.
*/
package pms_pkg;

   // Clock and timing, each time in its own unit
   localparam int CLK_HZ        = 25_000_000;
   localparam int TICK_HZ       = 1_000;
   localparam int GREEN_MIN_S   = 3;
   localparam int HOLD_BLINK_HZ = 1;
   localparam int PON_BLINK_MS  = 1_000;
   localparam int MS_PER_S      = 1_000;

   // Derived counts
   localparam int TICK_CYCLES   = CLK_HZ / TICK_HZ;
   localparam int GREEN_MIN_MS  = GREEN_MIN_S * MS_PER_S;
   localparam int BLINK_HALF_MS = MS_PER_S / (2 * HOLD_BLINK_HZ);

   // Register bus
   localparam int          ADDR_W    = 8;
   localparam int          DATA_W    = 32;
   localparam logic [7:0]  ADDR_CTRL = 8'h00;
   localparam logic [7:0]  ADDR_CMD  = 8'h04;
   localparam logic [7:0]  ADDR_STAT = 8'h08;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // Control register fields
   localparam int CTRL_RUN_BIT     = 0;
   localparam logic CTRL_RUN_RESET = 1'b0;

   // Command register fields, write-one pulses
   localparam int CMD_RESTART_BIT = 0;
   localparam int CMD_ORESET_BIT  = 1;
   localparam int CMD_RESUME_BIT  = 2;

   // Status register fields
   localparam int ST_MODE_LSB  = 0;
   localparam int ST_WDG_BIT   = 4;
   localparam int ST_GBUSY_BIT = 5;
   localparam int ST_YEL_BIT   = 6;
   localparam int ST_GRN_BIT   = 7;
   localparam int ST_RED_BIT   = 8;
   localparam int ST_LOCK_BIT  = 9;

   // Operating modes
   typedef enum logic [3:0] {
      MODE_STOP    = 4'h1,
      MODE_STARTUP = 4'h2,
      MODE_RUN     = 4'h4,
      MODE_HOLD    = 4'h8
   } pms_mode_t;

endpackage

// ### verilog/pms_tick_if.sv
/*
 Carrier of the millisecond enable and the blink phase from the
 tick divider to the timers and the indicator logic.
 Assumes one clock domain throughout.
*/
`timescale 1ns/1ns
`default_nettype none

interface pms_tick_if;
   logic tick;
   logic phase;
   modport gen  (output tick, output phase);
   modport sink (input tick, input phase);
endinterface // pms_tick_if

`default_nettype wire

// ### verilog/pms_tick_div.sv
/*
 Divider: one-cycle millisecond enable and a square blink phase.
 Assumes i_ref_clk is the system clock; reset is async active low.
*/
`timescale 1ns/1ns
`default_nettype none

module pms_tick_div #(
   parameter int TICK_CYCLES = pms_pkg::TICK_CYCLES,
   parameter int HALF_MS     = pms_pkg::BLINK_HALF_MS
) (
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   // Tick and phase out
   pms_tick_if.gen   tk
);
   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam int HW = $clog2(HALF_MS + 1);

   initial begin
      if (TICK_CYCLES < 2 || HALF_MS < 1) begin
         $error("pms_tick_div: bad divider parameters");
      end
   end

   logic [CW-1:0] cyc_ff;
   logic [HW-1:0] ms_ff;
   logic          tick_ff;
   logic          phase_ff;

   wire cyc_end = (cyc_ff == CW'(TICK_CYCLES - 1));
   wire ms_end  = (ms_ff == HW'(HALF_MS - 1));

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cyc_ff   <= '0;
         ms_ff    <= '0;
         tick_ff  <= 1'b0;
         phase_ff <= 1'b0;
      end else begin
         cyc_ff  <= cyc_end ? '0 : cyc_ff + CW'(1);
         tick_ff <= cyc_end;
         if (tick_ff) begin
            ms_ff    <= ms_end ? '0 : ms_ff + HW'(1);
            phase_ff <= ms_end ? ~phase_ff : phase_ff;
         end
      end
   end

   assign tk.tick  = tick_ff;
   assign tk.phase = phase_ff;

endmodule // pms_tick_div

`default_nettype wire

// ### verilog/pms_ms_timer.sv
/*
 Retriggerable millisecond timer: busy from a load for LOAD_MS ticks.
 Assumes the tick comes from pms_tick_div on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module pms_ms_timer #(
   parameter int MS_W    = 12,
   parameter int LOAD_MS = pms_pkg::GREEN_MIN_MS
) (
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   // Tick in
   pms_tick_if.sink  tk,
   // Control and state
   input  wire logic i_load,
   output logic      o_busy
);
   initial begin
      if (LOAD_MS < 1 || LOAD_MS >= (1 << MS_W)) begin
         $error("pms_ms_timer: LOAD_MS does not fit MS_W");
      end
   end

   logic [MS_W-1:0] left_ff;
   // The load sets exactly LOAD_MS ticks, so the busy span can fall short by part of one tick
   wire [MS_W-1:0] nxt_left = i_load ? MS_W'(LOAD_MS) :
                    (tk.tick && left_ff != '0) ? left_ff - MS_W'(1) :
                    left_ff;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         left_ff <= '0;
      end else begin
         left_ff <= nxt_left;
      end
   end

   assign o_busy = (left_ff != '0);

endmodule // pms_ms_timer

`default_nettype wire

// ### sim/pms_mode_chk.sv
/* Port checker of the mode sequencer.
   Assumes bench timing: 4-cycle tick, 2 ms blink, 6 ms green. */
`timescale 1ns/1ns
`default_nettype none
module pms_mode_chk (
   // Watched ports
   input wire logic       i_ref_clk,
   input wire logic       i_rst_n,
   input wire logic       i_cycle_end,
   input wire logic       i_watchdog_err,
   input wire logic [3:0] o_mode,
   input wire logic       o_output_disable_lock,
   input wire logic       o_exec_enable,
   input wire logic       o_startup_call,
   input wire logic       o_cycle_monitor_enable,
   input wire logic       o_timers_enable,
   input wire logic       o_image_refresh,
   input wire logic       o_yellow_led,
   input wire logic       o_green_led,
   input wire logic       o_red_led
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   logic [5:0] age_ff;
   logic [5:0] since_ff;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         age_ff <= 6'h00;
         since_ff <= 6'h00;
      end else begin
         age_ff <= age_ff + {5'h00, age_ff != 6'h3f};
         since_ff <= o_startup_call ? 6'h00
                   : since_ff + {5'h00, since_ff != 6'h3f};
      end
   end
   a_mode_onehot: assert property ($onehot(o_mode))
      else $error("mode not one-hot");
   a_stop_idle: assert property (o_mode==4'h1 |-> !o_exec_enable)
      else $error("code runs in stop");
   a_lock_mode: assert property (
      o_output_disable_lock == (o_mode != 4'h4))
      else $error("output lock wrong");
   a_yellow_steady: assert property (
      age_ff == 6'h3f && o_mode == 4'h1 |-> o_yellow_led)
      else $error("yellow not steady");
   a_call_entry: assert property (
      o_startup_call |-> o_mode == 4'h2 && $past(o_mode) == 4'h1)
      else $error("stray start-up call");
   a_start_unsup: assert property (
      o_mode == 4'h2 |-> !o_cycle_monitor_enable)
      else $error("start-up supervised");
   a_green_blink: assert property (
      o_startup_call |-> ##[1:16] !o_green_led ##[1:16] o_green_led)
      else $error("green not blinking");
   a_run_green: assert property (
      since_ff > 6'h28 && o_mode == 4'h4 |-> o_green_led)
      else $error("green not steady");
   a_run_image: assert property (
      o_mode == 4'h4 && i_cycle_end |=> o_image_refresh || o_mode != 4'h4)
      else $error("image not refreshed");
   a_hold_frozen: assert property (
      (o_mode == 4'h8) == (o_red_led && !o_timers_enable && !o_exec_enable))
      else $error("hold state wrong");
   a_wdg_stop: assert property (
      i_watchdog_err && o_mode != 4'h1 |=> o_mode == 4'h1)
      else $error("watchdog ignored");
endmodule // pms_mode_chk

bind pms_mode_seq pms_mode_chk u_pms_mode_chk (.*);
`default_nettype wire

// ### sim/pms_core_model.sv
/* Execution core stand-in: start-up completion and cycle ends.
   Assumes the sequencer's mode and call outputs on one clock. */
`timescale 1ns/1ns
`default_nettype none
module pms_core_model (
   // Clock, reset, sequencer side
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   input  wire logic [3:0] i_mode,
   input  wire logic       i_call,
   input  wire logic [7:0] i_startup_len,
   // Events back
   output logic            o_done,
   output logic            o_cycle_end
);
   logic [7:0] cnt_ff;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= 8'h00;
         o_done <= 1'b0;
         o_cycle_end <= 1'b0;
      end else begin
         // Start-up may take any length; nothing times it out
         cnt_ff <= i_call ? i_startup_len : cnt_ff - 8'h01;
         o_done <= i_mode == 4'h2 && cnt_ff == 8'h01;
         o_cycle_end <= i_mode == 4'h4 && cnt_ff[2:0] == 3'h0;
      end
   end
endmodule // pms_core_model
`default_nettype wire

// ### sim/tb_pms_mode_seq.sv
/* Bench of the mode sequencer with a core model.
   Assumes short timing set at the instance. */
`timescale 1ns/1ns
`default_nettype none
module tb_pms_mode_seq;
   logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_breakpoint = 1'b0;
   logic i_watchdog_err = 1'b0, i_cold_start_present = 1'b0;
   logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0;
   logic i_s_axi_bready = 1'b0, i_s_axi_arvalid = 1'b0;
   logic i_s_axi_rready = 1'b0, i_startup_done, i_cycle_end;
   logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
   logic [7:0] startup_len = 8'h03;
   logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, d;
   logic [3:0] i_s_axi_wstrb = 4'hf, o_mode;
   logic o_output_disable_lock, o_exec_enable, o_startup_call;
   logic o_startup_routine_active, o_cyclic_main_routine_active;
   logic o_cycle_monitor_enable, o_timers_enable, o_event_enable;
   logic o_image_refresh, o_yellow_led, o_green_led, o_red_led;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
   logic o_s_axi_arready, o_s_axi_rvalid, g, ha, hw, hb;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r;
   localparam logic [1:0] OK = pms_pkg::RESP_OKAY;
   localparam logic [1:0] ER = pms_pkg::RESP_SLVERR;
   int n_fail = 0, checks = 0, ncyc = 0;

   pms_mode_seq #(.TICK_CYCLES(4), .HALF_MS(2), .GREEN_MS(6), .PON_MS(4))
      u_pms_mode_seq (.*);
   pms_core_model u_pms_core_model (.i_ref_clk, .i_rst_n, .i_mode(o_mode),
      .i_call(o_startup_call), .i_startup_len(startup_len),
      .o_done(i_startup_done), .o_cycle_end(i_cycle_end));

   always #20 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      ncyc <= ncyc + 1;
      if (ncyc == 5000) begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (n_fail == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask
   task automatic wmode(input logic [3:0] m);
      do @(negedge i_ref_clk); while (o_mode !== m);
      chk(o_mode, m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] er);
      @(posedge i_ref_clk);
      {i_s_axi_awaddr, i_s_axi_wdata} <= {a, v};
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
      do begin
         @(negedge i_ref_clk);
         {ha, hw, hb, r} = {o_s_axi_awready, o_s_axi_wready,
                            o_s_axi_bvalid, o_s_axi_bresp};
         @(posedge i_ref_clk);
         if (ha) i_s_axi_awvalid <= 1'b0;
         if (hw) i_s_axi_wvalid <= 1'b0;
      end while (!hb);
      i_s_axi_bready <= 1'b0;
      chk(r, er);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     input logic [1:0] er);
      @(posedge i_ref_clk);
      {i_s_axi_araddr, i_s_axi_arvalid, i_s_axi_rready} <= {a, 2'h3};
      do begin
         @(negedge i_ref_clk);
         {ha, hb, v, r} = {o_s_axi_arready, o_s_axi_rvalid,
                           o_s_axi_rdata, o_s_axi_rresp};
         @(posedge i_ref_clk);
         if (ha) i_s_axi_arvalid <= 1'b0;
      end while (!hb);
      i_s_axi_rready <= 1'b0;
      chk(r, er);
   endtask
   task automatic wdg_pulse();
      @(posedge i_ref_clk);
      i_watchdog_err <= 1'b1;
      @(posedge i_ref_clk);
      i_watchdog_err <= 1'b0;
   endtask

   task automatic s_power_on();
      ticks(2);
      chk(o_mode, pms_pkg::MODE_STOP);
      chk(o_yellow_led, 1'b0);
      chk(o_output_disable_lock, 1'b1);
      rd(8'h00, d, OK);
      chk(d, 32'h0);
      rd(8'h0c, d, ER);
      wr(8'h0c, 32'h1, ER);
      ticks(60);
      chk(o_yellow_led, 1'b1);
   endtask
   task automatic s_start();
      wr(8'h00, 32'h1, OK);
      wmode(pms_pkg::MODE_STARTUP);
      chk(o_output_disable_lock, 1'b1);
      chk({o_cycle_monitor_enable, o_startup_routine_active}, 2'h1);
      wmode(pms_pkg::MODE_RUN);
      chk(o_output_disable_lock, 1'b0);
      chk(o_cyclic_main_routine_active & o_event_enable, 1'b1);
      chk(o_timers_enable, 1'b1);
      ticks(40);
      chk(o_green_led, 1'b1);
   endtask
   task automatic s_hold();
      @(posedge i_ref_clk);
      i_breakpoint <= 1'b1;
      @(posedge i_ref_clk);
      i_breakpoint <= 1'b0;
      wmode(pms_pkg::MODE_HOLD);
      chk(o_red_led & o_output_disable_lock, 1'b1);
      chk(o_timers_enable | o_exec_enable, 1'b0);
      g = o_green_led;
      ticks(8);
      chk(o_green_led, !g);
      wr(8'h04, 32'h4, OK);
      wmode(pms_pkg::MODE_RUN);
   endtask
   task automatic s_short();
      wr(8'h00, 32'h0, OK);
      wmode(pms_pkg::MODE_STOP);
      chk(o_exec_enable, 1'b0);
      startup_len <= 8'hff;
      wr(8'h00, 32'h1, OK);
      wmode(pms_pkg::MODE_STARTUP);
      wr(8'h00, 32'h0, OK);
      wmode(pms_pkg::MODE_STOP);
      g = o_green_led;
      ticks(8);
      chk(o_green_led, !g);
      chk(o_yellow_led & o_output_disable_lock, 1'b1);
   endtask
   task automatic s_watchdog();
      startup_len <= 8'h03;
      wr(8'h00, 32'h1, OK);
      wmode(pms_pkg::MODE_RUN);
      wdg_pulse();
      wmode(pms_pkg::MODE_STOP);
      rd(8'h08, d, OK);
      chk(d[pms_pkg::ST_WDG_BIT], 1'b1);
      wr(8'h04, 32'h1, OK);
      ticks(4);
      chk(o_mode, pms_pkg::MODE_STOP);
      i_cold_start_present <= 1'b1;
      wr(8'h04, 32'h1, OK);
      wmode(pms_pkg::MODE_STARTUP);
      wmode(pms_pkg::MODE_RUN);
      wdg_pulse();
      wmode(pms_pkg::MODE_STOP);
      wr(8'h04, 32'h2, OK);
      wmode(pms_pkg::MODE_STARTUP);
   endtask

   initial begin
      repeat (3) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      s_power_on();
      s_start();
      s_hold();
      s_short();
      s_watchdog();
      report_and_stop();
   end
endmodule // tb_pms_mode_seq
`default_nettype wire
